// ### logic/swd_pkg.sv
// swd_pkg: constants, types and carriers for the staged watchdog block.
// assumes a single 25 MHz clock, synchronous active-low reset.
package swd_pkg;
   localparam int SWD_CLK_HZ = 25000000;
   localparam int SWD_NUM_DOGS = 3;
   localparam int SWD_NUM_STAGES = 4;
   localparam int SWD_CNT_W = 32;
   // dog indices
   localparam int SWD_DOG_MAIN0 = 0;
   localparam int SWD_DOG_MAIN1 = 1;
   localparam int SWD_DOG_AON = 2;
   // fallback slow clock: about 32 kHz from the 25 MHz source
   localparam int SWD_FALLBACK_HZ = 32000;
   localparam int SWD_FALLBACK_HALF = SWD_CLK_HZ / (2 * SWD_FALLBACK_HZ);
   // crystal declared dead after this many microseconds without a crystal edge
   localparam int SWD_XTAL_DEAD_US = 100;
   localparam int SWD_XTAL_DEAD_CYC = (SWD_XTAL_DEAD_US * (SWD_CLK_HZ / 1000000));
   // flash boot time limit, milliseconds
   localparam int SWD_BOOT_LIMIT_MS = 1000;
   localparam int SWD_BOOT_LIMIT_CYC = SWD_BOOT_LIMIT_MS * (SWD_CLK_HZ / 1000);
   // protection unlock key
   localparam logic [31:0] SWD_UNLOCK_KEY = 32'h50d83aa1;
   // reset values
   localparam logic [31:0] SWD_RST_TIMEOUT = 32'h00ffffff;
   localparam logic [3:0] SWD_RST_STAGE_EN = 4'h0;

   typedef enum logic [2:0]
   {
      SWD_ACT_NONE = 3'h0,
      SWD_ACT_INT = 3'h1,
      SWD_ACT_CPU_RST = 3'h2,
      SWD_ACT_CORE_RST = 3'h3,
      SWD_ACT_SYS_RST = 3'h4
   } swd_action_t;

   // stage counter state, gray along stage0..3
   typedef enum logic [1:0]
   {
      SWD_ST0 = 2'h0,
      SWD_ST1 = 2'h1,
      SWD_ST2 = 2'h3,
      SWD_ST3 = 2'h2
   } swd_stage_t;

   // configuration write, one dog, one stage
   typedef struct packed {
      logic valid;
      logic [1:0] dog;
      logic [1:0] stage;
      logic enable;
      swd_action_t action;
      logic [SWD_CNT_W-1:0] timeout;
   } swd_cfg_wr_t;

   // per-dog outcome
   typedef struct packed {
      logic interrupt;
      logic cpuReset;
      logic coreReset;
      logic sysReset;
   } swd_event_t;
endpackage : swd_pkg

// ### logic/swd_staged_watchdog.sv
// swd_staged_watchdog: three four-stage watchdogs, flash boot guard and
// slow crystal monitor with fallback clock. assumes software drives the
// control ports from logic on clk; the crystal input is asynchronous.
//
// What this block does
// - three independent watchdogs: two main-system, one always-on.
// - four sequential stages per dog, each timeout counted by 32-bit counter.
// - each stage individually configured and enabled; disabled stage still times out but takes no action.
// - main-system stage expiry: interrupt, CPU reset or core reset.
// - always-on stage expiry: interrupt, CPU, core or full system reset.
// - configuration of all dogs is write-protected unless unlocked.
// - flash boot arms always-on dog and first main dog automatically.
// - flash boot not done within limit reboots whole main system.
// - stopped slow crystal raises crystal failure interrupt.
// - crystal failure wakes CPU when in light or deep sleep.
// - on crystal failure a fallback 32 kHz clock replaces the crystal.
`timescale 1ns/1ns
module swd_staged_watchdog
   import swd_pkg::*;
#(
   parameter int BOOT_LIMIT_CYC = SWD_BOOT_LIMIT_CYC,
   parameter int XTAL_DEAD_CYC = SWD_XTAL_DEAD_CYC
)
(
   input wire logic clk,
   input wire logic reset_n,
   input wire logic flashBoot,
   input wire logic bootDone,
   input wire logic [31:0] protectKey,
   input wire logic protectKeyWr,
   input wire swd_cfg_wr_t cfgWr,
   input wire logic [SWD_NUM_DOGS-1:0] dogRun,
   input wire logic [SWD_NUM_DOGS-1:0] feed,
   input wire logic [SWD_NUM_DOGS-1:0] intClear,
   input wire logic slowCrystalClock,
   input wire logic cpuSleeping,
   input wire logic xtalFailClear,
   output logic [SWD_NUM_DOGS-1:0] dogInterrupt,
   output logic cpuReset,
   output logic coreReset,
   output logic sysReset,
   output logic mainSysReboot,
   output logic crystalFailureInterrupt,
   output logic cpuWake,
   output logic slowClockSel,
   output logic fallbackSlowClock,
   output logic slowClockOut,
   output logic protectLocked
);
   // per-dog state
   logic [SWD_NUM_DOGS-1:0] runFF, nxt_run;
   swd_stage_t stageFF [SWD_NUM_DOGS];
   swd_stage_t nxt_stage [SWD_NUM_DOGS];
   logic [SWD_CNT_W-1:0] cntFF [SWD_NUM_DOGS];
   logic [SWD_CNT_W-1:0] nxt_cnt [SWD_NUM_DOGS];
   logic [SWD_CNT_W-1:0] toFF [SWD_NUM_DOGS][SWD_NUM_STAGES];
   logic [SWD_CNT_W-1:0] nxt_to [SWD_NUM_DOGS][SWD_NUM_STAGES];
   swd_action_t actFF [SWD_NUM_DOGS][SWD_NUM_STAGES];
   swd_action_t nxt_act [SWD_NUM_DOGS][SWD_NUM_STAGES];
   logic [SWD_NUM_STAGES-1:0] enFF [SWD_NUM_DOGS];
   logic [SWD_NUM_STAGES-1:0] nxt_en [SWD_NUM_DOGS];
   logic [SWD_NUM_DOGS-1:0] intFF, nxt_int;
   logic cpuRstFF, nxt_cpuRst, coreRstFF, nxt_coreRst, sysRstFF, nxt_sysRst;
   logic lockedFF, nxt_locked;
   logic bootArmedFF, nxt_bootArmed;
   logic [31:0] bootCntFF, nxt_bootCnt;
   logic rebootFF, nxt_reboot;
   logic bootS1FF, bootS2FF, releaseFF;
   // crystal monitor state
   logic xtalS1FF, xtalS2FF, xtalS3FF;
   logic [31:0] deadCntFF, nxt_deadCnt;
   logic xtalDeadFF, nxt_xtalDead;
   logic xtalIntFF, nxt_xtalInt;
   logic wakeFF, nxt_wake;
   logic [15:0] divCntFF, nxt_divCnt;
   logic fallbackFF, nxt_fallback;
   logic slowOutFF, nxt_slowOut;

   function automatic swd_stage_t swd_next_stage(input swd_stage_t s);
      case (s)
         SWD_ST0: swd_next_stage = SWD_ST1;
         SWD_ST1: swd_next_stage = SWD_ST2;
         SWD_ST2: swd_next_stage = SWD_ST3;
         default: swd_next_stage = SWD_ST0;
      endcase
   endfunction : swd_next_stage

   function automatic logic [1:0] swd_stage_idx(input swd_stage_t s);
      case (s)
         SWD_ST0: swd_stage_idx = 2'h0;
         SWD_ST1: swd_stage_idx = 2'h1;
         SWD_ST2: swd_stage_idx = 2'h2;
         default: swd_stage_idx = 2'h3;
      endcase
   endfunction : swd_stage_idx

   // watchdogs, protection, boot guard
   always_comb
   begin
      logic [1:0] si;
      logic expire;
      swd_action_t act;
      si = 2'h0;
      expire = 1'b0;
      act = SWD_ACT_NONE;
      nxt_run = runFF;
      nxt_int = intFF;
      nxt_cpuRst = 1'b0;
      nxt_coreRst = 1'b0;
      nxt_sysRst = 1'b0;
      nxt_locked = lockedFF;
      nxt_bootArmed = bootArmedFF;
      nxt_bootCnt = bootCntFF;
      nxt_reboot = 1'b0;
      for (int d = 0; d < SWD_NUM_DOGS; d++)
      begin
         nxt_stage[d] = stageFF[d];
         nxt_cnt[d] = cntFF[d];
         nxt_en[d] = enFF[d];
         for (int s = 0; s < SWD_NUM_STAGES; s++)
         begin
            nxt_to[d][s] = toFF[d][s];
            nxt_act[d][s] = actFF[d][s];
         end
      end
      if (protectKeyWr)
      begin
         nxt_locked = (protectKey != SWD_UNLOCK_KEY);
      end
      if (cfgWr.valid && !lockedFF && cfgWr.dog < 2'(SWD_NUM_DOGS))
      begin
         nxt_to[cfgWr.dog][cfgWr.stage] = cfgWr.timeout;
         nxt_en[cfgWr.dog][cfgWr.stage] = cfgWr.enable;
         // a main dog cannot take a system reset
         if (cfgWr.dog != 2'(SWD_DOG_AON) && cfgWr.action == SWD_ACT_SYS_RST)
         begin
            nxt_act[cfgWr.dog][cfgWr.stage] = SWD_ACT_CORE_RST;
         end
         else
         begin
            nxt_act[cfgWr.dog][cfgWr.stage] = cfgWr.action;
         end
      end
      for (int d = 0; d < SWD_NUM_DOGS; d++)
      begin
         if (!lockedFF || (bootArmedFF && d != SWD_DOG_MAIN1))
         begin
            nxt_run[d] = dogRun[d] | (bootArmedFF && d != SWD_DOG_MAIN1);
         end
         si = swd_stage_idx(stageFF[d]);
         expire = runFF[d] && cntFF[d] >= toFF[d][si];
         act = actFF[d][si];
         if (feed[d])
         begin
            nxt_stage[d] = SWD_ST0;
            nxt_cnt[d] = '0;
         end
         else if (expire)
         begin
            nxt_stage[d] = swd_next_stage(stageFF[d]);
            nxt_cnt[d] = '0;
            if (enFF[d][si])
            begin
               case (act)
                  SWD_ACT_INT: nxt_int[d] = 1'b1;
                  SWD_ACT_CPU_RST: nxt_cpuRst = 1'b1;
                  SWD_ACT_CORE_RST: nxt_coreRst = 1'b1;
                  SWD_ACT_SYS_RST: nxt_sysRst = (d == SWD_DOG_AON);
                  default: ;
               endcase
            end
         end
         else if (runFF[d])
         begin
            nxt_cnt[d] = cntFF[d] + 32'h1;
         end
         // set wins over clear
         if (intClear[d] && !(expire && enFF[d][si] && act == SWD_ACT_INT))
         begin
            nxt_int[d] = 1'b0;
         end
      end
      if (!releaseFF && bootS2FF)
      begin
         nxt_bootArmed = 1'b1;
      end
      if (bootArmedFF)
      begin
         if (bootDone)
         begin
            nxt_bootArmed = 1'b0;
         end
         else if (bootCntFF >= 32'(BOOT_LIMIT_CYC - 1))
         begin
            nxt_reboot = 1'b1;
            nxt_bootCnt = '0;
         end
         else
         begin
            nxt_bootCnt = bootCntFF + 32'h1;
         end
      end
   end

   always_ff @(posedge clk)
   begin
      if (!reset_n)
      begin
         runFF <= '0;
         intFF <= '0;
         cpuRstFF <= 1'b0;
         coreRstFF <= 1'b0;
         sysRstFF <= 1'b0;
         lockedFF <= 1'b1;
         bootArmedFF <= 1'b0;
         bootCntFF <= '0;
         rebootFF <= 1'b0;
         for (int d = 0; d < SWD_NUM_DOGS; d++)
         begin
            stageFF[d] <= SWD_ST0;
            cntFF[d] <= '0;
            enFF[d] <= SWD_RST_STAGE_EN;
            for (int s = 0; s < SWD_NUM_STAGES; s++)
            begin
               toFF[d][s] <= SWD_RST_TIMEOUT;
               actFF[d][s] <= SWD_ACT_NONE;
            end
         end
      end
      else
      begin
         runFF <= nxt_run;
         intFF <= nxt_int;
         cpuRstFF <= nxt_cpuRst;
         coreRstFF <= nxt_coreRst;
         sysRstFF <= nxt_sysRst;
         lockedFF <= nxt_locked;
         bootArmedFF <= nxt_bootArmed;
         bootCntFF <= nxt_bootCnt;
         rebootFF <= nxt_reboot;
         stageFF <= nxt_stage;
         cntFF <= nxt_cnt;
         enFF <= nxt_en;
         toFF <= nxt_to;
         actFF <= nxt_act;
      end
   end

   // strap synchroniser and reset-release marker; no reset, they only follow their inputs
   always_ff @(posedge clk)
   begin
      bootS1FF <= flashBoot;
      bootS2FF <= bootS1FF;
      releaseFF <= reset_n;
   end

   // crystal monitor
   always_comb
   begin
      nxt_deadCnt = deadCntFF;
      nxt_xtalDead = xtalDeadFF;
      nxt_xtalInt = xtalIntFF;
      nxt_wake = 1'b0;
      nxt_divCnt = divCntFF + 16'h1;
      nxt_fallback = fallbackFF;
      if (xtalS2FF != xtalS3FF)
      begin
         nxt_deadCnt = '0;
      end
      else if (!xtalDeadFF && deadCntFF >= 32'(XTAL_DEAD_CYC - 1))
      begin
         nxt_xtalDead = 1'b1;
         nxt_xtalInt = 1'b1;
         nxt_wake = cpuSleeping;
      end
      else
      begin
         nxt_deadCnt = deadCntFF + 32'h1;
      end
      if (xtalFailClear && !nxt_wake && xtalDeadFF)
      begin
         nxt_xtalInt = 1'b0;
      end
      if (divCntFF >= 16'(SWD_FALLBACK_HALF - 1))
      begin
         nxt_divCnt = '0;
         nxt_fallback = !fallbackFF;
      end
      nxt_slowOut = xtalDeadFF ? fallbackFF : xtalS2FF;
   end

   always_ff @(posedge clk)
   begin
      if (!reset_n)
      begin
         xtalS1FF <= 1'b0;
         xtalS2FF <= 1'b0;
         xtalS3FF <= 1'b0;
         deadCntFF <= '0;
         xtalDeadFF <= 1'b0;
         xtalIntFF <= 1'b0;
         wakeFF <= 1'b0;
         divCntFF <= '0;
         fallbackFF <= 1'b0;
         slowOutFF <= 1'b0;
      end
      else
      begin
         xtalS1FF <= slowCrystalClock;
         xtalS2FF <= xtalS1FF;
         xtalS3FF <= xtalS2FF;
         deadCntFF <= nxt_deadCnt;
         xtalDeadFF <= nxt_xtalDead;
         xtalIntFF <= nxt_xtalInt;
         wakeFF <= nxt_wake;
         divCntFF <= nxt_divCnt;
         fallbackFF <= nxt_fallback;
         slowOutFF <= nxt_slowOut;
      end
   end

   assign dogInterrupt = intFF;
   assign cpuReset = cpuRstFF;
   assign coreReset = coreRstFF;
   assign sysReset = sysRstFF;
   assign mainSysReboot = rebootFF;
   assign crystalFailureInterrupt = xtalIntFF;
   assign cpuWake = wakeFF;
   assign slowClockSel = xtalDeadFF;
   assign fallbackSlowClock = fallbackFF;
   assign slowClockOut = slowOutFF;
   assign protectLocked = lockedFF;
endmodule : swd_staged_watchdog

// ### verification/swd_xtal_osc.sv
// swd_xtal_osc: slow crystal stand-in, scaled so edges come well inside the dead limit.
// assumes the bench stops it by lowering xtalAlive; a stopped crystal holds its level.
`timescale 1ns/1ns
module swd_xtal_osc
(
   input wire logic xtalAlive,
   output logic xtal
);
   initial xtal = 1'b0;
   always #150 if (xtalAlive) xtal = ~xtal;
endmodule : swd_xtal_osc

// ### verification/swd_watchdog_properties.sv
// swd_watchdog_properties: concurrent checks on the watchdog top ports.
// assumes bind from the bench, one clock, synchronous active-low reset.
`timescale 1ns/1ns
module swd_watchdog_properties
   import swd_pkg::*;
(
   input wire logic clk,
   input wire logic reset_n,
   input wire logic [31:0] protectKey,
   input wire logic protectKeyWr,
   input wire logic protectLocked,
   input wire logic [SWD_NUM_DOGS-1:0] dogInterrupt,
   input wire logic [SWD_NUM_DOGS-1:0] intClear,
   input wire logic slowClockSel,
   input wire logic crystalFailureInterrupt,
   input wire logic xtalFailClear,
   input wire logic cpuWake,
   input wire logic cpuSleeping,
   input wire logic fallbackSlowClock
);
   default clocking @(posedge clk); endclocking
   default disable iff (!reset_n);
   chk_key_unlock:
      assert property (protectKeyWr && protectKey == SWD_UNLOCK_KEY |=> !protectLocked)
      else $error("unlock key left lock set");
   chk_key_lock:
      assert property (protectKeyWr && protectKey != SWD_UNLOCK_KEY |=> protectLocked)
      else $error("wrong key did not lock");
   chk_lock_hold:
      assert property (!protectKeyWr |=> $stable(protectLocked))
      else $error("lock changed without key write");
   chk_sel_sticky:
      assert property (slowClockSel |=> slowClockSel)
      else $error("fallback select dropped");
   chk_int_with_sel:
      assert property ($rose(slowClockSel) |-> crystalFailureInterrupt)
      else $error("switch without crystal failure interrupt");
   chk_wake_cause:
      assert property (cpuWake |-> $rose(slowClockSel) && $past(cpuSleeping))
      else $error("wake without failure in sleep");
   chk_fallback_half:
      assert property ($changed(fallbackSlowClock) |=> $stable(fallbackSlowClock) [*8])
      else $error("fallback clock toggles too fast");
   chk_dog_int_hold:
      assert property (dogInterrupt[0] && !intClear[0] |=> dogInterrupt[0])
      else $error("dog interrupt dropped without clear");
   chk_xint_hold:
      assert property (crystalFailureInterrupt && !xtalFailClear |=> crystalFailureInterrupt)
      else $error("crystal interrupt dropped without clear");
endmodule : swd_watchdog_properties

// ### verification/tb_top.sv
// tb_top: self-checking bench for the staged watchdog block.
// assumes 25 MHz clk, inputs driven at the falling edge.
`timescale 1ns/1ns
module tb_top;
   import swd_pkg::*;
   localparam int BOOT = 50;
   localparam int DEAD = 40;
   logic clk = 1'b0;
   logic reset_n = 1'b0;
   logic flashBoot = 1'b0;
   logic bootDone = 1'b0;
   logic [31:0] protectKey = 32'h0;
   logic protectKeyWr = 1'b0;
   swd_cfg_wr_t cfgWr = '0;
   logic [2:0] dogRun = 3'h0;
   logic [2:0] feed = 3'h0;
   logic [2:0] intClear = 3'h0;
   logic slowCrystalClock;
   logic cpuSleeping = 1'b1;
   logic xtalFailClear = 1'b0;
   logic xtalAlive = 1'b1;
   logic [2:0] dogInterrupt;
   logic cpuReset, coreReset, sysReset, mainSysReboot, crystalFailureInterrupt, cpuWake;
   logic slowClockSel, fallbackSlowClock, slowClockOut, protectLocked;
   int miscompares = 0;
   int tests_run = 0;
   int seed = 1642;
   time lastXtal = 0;
   always #20 clk = ~clk;
   always @(slowCrystalClock) lastXtal = $time;
   swd_xtal_osc xosc (.xtalAlive, .xtal(slowCrystalClock));
   swd_staged_watchdog #(.BOOT_LIMIT_CYC(BOOT), .XTAL_DEAD_CYC(DEAD)) uut (.clk, .reset_n,
      .flashBoot, .bootDone, .protectKey, .protectKeyWr, .cfgWr, .dogRun, .feed, .intClear,
      .slowCrystalClock, .cpuSleeping, .xtalFailClear, .dogInterrupt, .cpuReset, .coreReset,
      .sysReset, .mainSysReboot, .crystalFailureInterrupt, .cpuWake, .slowClockSel,
      .fallbackSlowClock, .slowClockOut, .protectLocked);
   task automatic print_verdict();
      $display("comparisons %0d mismatches %0d", tests_run, miscompares);
      if (miscompares == 0 && tests_run > 0)
         $display("ALL CHECKS OK");
      else
         $display("CHECKS NOT OK");
      $finish;
   endtask : print_verdict
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      tests_run++;
      if (seen !== exp)
      begin
         miscompares++;
         $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask : check
   task automatic bound(input int n, input int lim);
      if (n >= lim)
      begin
         miscompares++;
         print_verdict();
      end
   endtask : bound
   task automatic key(input logic [31:0] k);
      @(negedge clk);
      protectKey = k;
      protectKeyWr = 1'b1;
      @(negedge clk);
      protectKeyWr = 1'b0;
   endtask : key
   task automatic cfg(input int d, input int s, input int en, input swd_action_t a, input int t);
      @(negedge clk);
      cfgWr = '{1'b1, d[1:0], s[1:0], en[0], a, t};
      @(negedge clk);
      cfgWr.valid = 1'b0;
   endtask : cfg
   // feeds nf extra times every t cycles, then waits for the stage s action
   task automatic go(input int d, input int s, input swd_action_t a, input int t, input int nf);
      int n, lim, i;
      logic [3:0] ev, exp;
      exp = {a == SWD_ACT_INT, a == SWD_ACT_CPU_RST,
         a == SWD_ACT_CORE_RST || (a == SWD_ACT_SYS_RST && d != SWD_DOG_AON),
         a == SWD_ACT_SYS_RST && d == SWD_DOG_AON};
      lim = (s + 1) * (t + 1) + 10;
      n = 0;
      ev = 4'h0;
      @(negedge clk);
      dogRun[d] = 1'b1;
      for (i = 0; i <= nf; i++)
      begin
         if (i > 0)
            repeat (t - 1) @(negedge clk);
         feed[d] = 1'b1;
         @(negedge clk);
         feed[d] = 1'b0;
      end
      while (ev === 4'h0 && n < lim)
      begin
         @(negedge clk);
         n++;
         ev = {dogInterrupt[d], cpuReset, coreReset, sysReset};
      end
      bound(n, lim);
      check(ev, exp);
      check(n >= (s + 1) * (t + 1), 1);
      dogRun[d] = 1'b0;
      intClear[d] = 1'b1;
      @(negedge clk);
      intClear[d] = 1'b0;
      @(negedge clk);
      check(dogInterrupt[d], 0);
   endtask : go
   task automatic run_case(input int d, input int s, input swd_action_t a, input int t);
      for (int i = 0; i < 4; i++)
         cfg(d, i, i == s, a, t);
      go(d, s, a, t, 2);
   endtask : run_case
   initial
   begin
      int n, t, s;
      logic prev;
      repeat (8) @(negedge clk);
      reset_n = 1'b1;
      @(negedge clk);
      check(protectLocked, 1);
      cfg(0, 0, 1, SWD_ACT_INT, 2);
      dogRun[0] = 1'b1;
      repeat (20) @(negedge clk);
      check(dogInterrupt, 0);
      dogRun[0] = 1'b0;
      $display("test locked done");
      key(SWD_UNLOCK_KEY);
      check(protectLocked, 0);
      for (int d = 0; d < 3; d++)
         for (int a = 1; a < 5; a++)
         begin
            t = 2 + ($unsigned($random(seed)) % 6);
            s = $unsigned($random(seed)) % 4;
            run_case(d, s, swd_action_t'(a), t);
         end
      $display("test stages done");
      run_case(0, 0, SWD_ACT_INT, 3);
      key(32'h0);
      check(protectLocked, 1);
      cfg(0, 0, 0, SWD_ACT_INT, 3);
      key(SWD_UNLOCK_KEY);
      go(0, 0, SWD_ACT_INT, 3, 0);
      $display("test refusal done");
      repeat (100) @(negedge clk);
      check(slowClockSel, 0);
      xtalAlive = 1'b0;
      n = 0;
      while (crystalFailureInterrupt !== 1'b1 && n < DEAD + 20)
      begin
         @(negedge clk);
         n++;
      end
      bound(n, DEAD + 20);
      check($time - lastXtal >= DEAD * 40, 1);
      check({cpuWake, slowClockSel}, 2'h3);
      xtalFailClear = 1'b1;
      @(negedge clk);
      xtalFailClear = 1'b0;
      @(negedge clk);
      check({cpuWake, crystalFailureInterrupt, slowClockSel}, 3'h1);
      n = 0;
      prev = slowClockOut;
      for (int i = 0; i < 1600; i++)
      begin
         @(negedge clk);
         n += (slowClockOut !== prev);
         prev = slowClockOut;
      end
      check(n >= 1600 / SWD_FALLBACK_HALF && n <= 1600 / SWD_FALLBACK_HALF + 1, 1);
      $display("test crystal done");
      flashBoot = 1'b1;
      cpuSleeping = 1'b0;
      reset_n = 1'b0;
      repeat (8) @(negedge clk);
      reset_n = 1'b1;
      @(negedge clk);
      check({protectLocked, slowClockSel}, 2'h2);
      n = 0;
      while (mainSysReboot !== 1'b1 && n < BOOT + 20)
      begin
         @(negedge clk);
         n++;
      end
      bound(n, BOOT + 20);
      check(mainSysReboot, 1);
      check(n >= BOOT, 1);
      key(SWD_UNLOCK_KEY);
      for (int d = 0; d < 3; d++)
         cfg(d, 0, 1, SWD_ACT_INT, 3);
      repeat (20) @(negedge clk);
      check(dogInterrupt, 3'h5);
      check({crystalFailureInterrupt, slowClockSel, cpuWake}, 3'h6);
      bootDone = 1'b1;
      @(negedge clk);
      bootDone = 1'b0;
      n = 0;
      repeat (BOOT + 5)
      begin
         @(negedge clk);
         n += mainSysReboot;
      end
      check(n, 0);
      $display("test boot done");
      print_verdict();
   end
endmodule : tb_top
bind swd_staged_watchdog swd_watchdog_properties u_chk (.clk, .reset_n, .protectKey,
   .protectKeyWr, .protectLocked, .dogInterrupt, .intClear, .slowClockSel,
   .crystalFailureInterrupt, .xtalFailClear, .cpuWake, .cpuSleeping, .fallbackSlowClock);
